// ### src/pin_sync.sv
// module: two-flop synchroniser for pin levels
// assumes: inputs asynchronous to pclk
`timescale 1ns/1ps
module pin_sync #(parameter int W = 2) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pin_sync

// ### src/pin_unit.sv
// module: compare output and capture edge logic for one timer pin
// assumes: pin_in already synchronised, counter and greg on pclk
`timescale 1ns/1ps
module pin_unit
  import timer_ch4_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pin_unit_if.unit pu
);
  pin_func_t func;
  logic pin_prev;
  logic rise;
  logic fall;
  logic out_mode;
  logic drives;
  logic match_hit;
  logic capt_hit;
  logic next_pin;

  assign func = decode_func(pu.field);
  assign out_mode = !pu.field[SEL_INPUT_BIT];
  assign rise = pu.pin_in & ~pin_prev;
  assign fall = ~pu.pin_in & pin_prev;
  assign drives = (func == FUNC_CLEAR) || (func == FUNC_SET) || (func == FUNC_TOGGLE);
  // compare match only on a counter step that lands on the register
  assign match_hit = out_mode && !pu.blocked && pu.count_step
                     && (pu.counter == pu.greg);
  assign capt_hit = !out_mode && !pu.blocked && (
                    (func == FUNC_CAPT_RISE && rise) ||
                    (func == FUNC_CAPT_FALL && fall) ||
                    (func == FUNC_CAPT_BOTH && (rise || fall)));
  assign pu.match = match_hit;
  assign pu.capture = capt_hit;

  always_comb begin
    next_pin = pu.pin_out;
    if (pu.init_load && drives && !pu.blocked) begin
      next_pin = pu.field[SEL_INIT_BIT];
    end else if (match_hit) begin
      unique case (func)
        FUNC_CLEAR: next_pin = 1'b0;
        FUNC_SET: next_pin = 1'b1;
        FUNC_TOGGLE: next_pin = ~pu.pin_out;
        default: next_pin = pu.pin_out;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 1'b0;
      pu.pin_out <= PIN_RST;
      pu.pin_oe <= OE_RST;
    end else begin
      pin_prev <= pu.pin_in;
      pu.pin_out <= next_pin;
      pu.pin_oe <= out_mode;
    end
  end
endmodule : pin_unit

// ### src/pin_unit_if.sv
// interface: one pin's control, compare and capture signals
// assumes: driven by the top on pclk, consumed by pin_unit
`timescale 1ns/1ps
interface pin_unit_if #(parameter int CNT_W = 16);
  logic [3:0] field;
  logic blocked;
  logic init_load;
  logic count_step;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] greg;
  logic pin_in;
  logic pin_out;
  logic pin_oe;
  logic match;
  logic capture;
  modport unit (input field, blocked, init_load, count_step, counter, greg, pin_in,
                output pin_out, pin_oe, match, capture);
  modport host (output field, blocked, init_load, count_step, counter, greg, pin_in,
                input pin_out, pin_oe, match, capture);
endinterface : pin_unit_if

// ### src/timer_ch4_io_control_cd.sv
// module: channel 4 pin c/d function select with compare, capture, apb regs
// assumes: counter_value and count_step come from the channel counter on pclk;
// pins are asynchronous and synchronised here
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module timer_ch4_io_control_cd
  import timer_ch4_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_ch4_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_step,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic channel4_pin_c_in,
  output logic channel4_pin_c_out,
  output logic channel4_pin_c_oe,
  input wire logic channel4_pin_d_in,
  output logic channel4_pin_d_out,
  output logic channel4_pin_d_oe,
  output logic irq
);
  import timer_ch4_pkg::*;

  logic [7:0] channel4_pin_cd_io_control;
  logic [1:0] channel4_timer_mode_reg;
  logic [CNT_W-1:0] channel4_general_reg_c;
  logic [CNT_W-1:0] channel4_general_reg_d;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] next_status;
  logic [1:0] pins_sync;
  logic io_written;

  pin_unit_if #(.CNT_W(CNT_W)) pu_c ();
  pin_unit_if #(.CNT_W(CNT_W)) pu_d ();

  // apb decode
  wire setup_phase = psel && !penable;
  wire sel_io = (paddr == OFS_IO_CONTROL);
  wire sel_mode = (paddr == OFS_MODE);
  wire sel_greg_c = (paddr == OFS_GREG_C);
  wire sel_greg_d = (paddr == OFS_GREG_D);
  wire sel_status = (paddr == OFS_STATUS);
  wire sel_mask = (paddr == OFS_MASK);
  wire addr_hit = sel_io || sel_mode || sel_greg_c || sel_greg_d
                  || sel_status || sel_mask;
  wire wr_take = psel && penable && pready && pwrite && addr_hit;
  wire wr_io = wr_take && sel_io;
  wire wr_mode = wr_take && sel_mode;
  wire wr_greg_c = wr_take && sel_greg_c;
  wire wr_greg_d = wr_take && sel_greg_d;
  wire wr_status = wr_take && sel_status;
  wire wr_mask = wr_take && sel_mask;

  wire [31:0] rd_io = {24'h000000, channel4_pin_cd_io_control};
  wire [31:0] rd_mode = {30'h00000000, channel4_timer_mode_reg};
  wire [31:0] rd_greg_c = {{(32-CNT_W){1'b0}}, channel4_general_reg_c};
  wire [31:0] rd_greg_d = {{(32-CNT_W){1'b0}}, channel4_general_reg_d};
  wire [31:0] rd_status = {28'h0000000, status};
  wire [31:0] rd_mask = {28'h0000000, mask};
  wire [31:0] read_word = sel_io ? rd_io :
                          sel_mode ? rd_mode :
                          sel_greg_c ? rd_greg_c :
                          sel_greg_d ? rd_greg_d :
                          sel_status ? rd_status :
                          sel_mask ? rd_mask : 32'h00000000;

  // the c register is the buffer of a, the d register the buffer of b
  wire block_c = channel4_timer_mode_reg[MODE_BUF_A_BIT];
  wire block_d = channel4_timer_mode_reg[MODE_BUF_B_BIT];

  // write one to clear; a hardware event in the same cycle wins
  wire [ST_W-1:0] st_clear = wr_status ? pwdata[ST_W-1:0] : 4'h0;
  wire [ST_W-1:0] st_event = {pu_d.capture, pu_d.match, pu_c.capture, pu_c.match};

  assign next_status = (status & ~st_clear) | st_event;

  // apb slave: one wait-free access phase, read data latched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_hit;
      if (setup_phase) begin
        prdata <= (!pwrite && addr_hit) ? read_word : 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel4_pin_cd_io_control <= IO_CONTROL_RST;
      channel4_timer_mode_reg <= MODE_RST;
      mask <= MASK_RST;
      io_written <= 1'b0;
    end else begin
      io_written <= wr_io;
      if (wr_io) begin
        channel4_pin_cd_io_control <= pwdata[7:0];
      end
      if (wr_mode) begin
        channel4_timer_mode_reg <= pwdata[1:0];
      end
      if (wr_mask) begin
        mask <= pwdata[ST_W-1:0];
      end
    end
  end

  // capture beats a software write to the same register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel4_general_reg_c <= '0;
    end else if (pu_c.capture) begin
      channel4_general_reg_c <= counter_value;
    end else if (wr_greg_c) begin
      channel4_general_reg_c <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel4_general_reg_d <= '0;
    end else if (pu_d.capture) begin
      channel4_general_reg_d <= counter_value;
    end else if (wr_greg_d) begin
      channel4_general_reg_d <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RST;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(status & mask);
    end
  end

  pin_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({channel4_pin_d_in, channel4_pin_c_in}),
    .q(pins_sync)
  );

  // initial level is applied the cycle after the field is written
  assign pu_c.field = channel4_pin_cd_io_control[FLD_C_LSB+:4];
  assign pu_c.blocked = block_c;
  assign pu_c.init_load = io_written;
  assign pu_c.count_step = count_step;
  assign pu_c.counter = counter_value;
  assign pu_c.greg = channel4_general_reg_c;
  assign pu_c.pin_in = pins_sync[0];

  assign pu_d.field = channel4_pin_cd_io_control[FLD_D_LSB+:4];
  assign pu_d.blocked = block_d;
  assign pu_d.init_load = io_written;
  assign pu_d.count_step = count_step;
  assign pu_d.counter = counter_value;
  assign pu_d.greg = channel4_general_reg_d;
  assign pu_d.pin_in = pins_sync[1];

  pin_unit u_unit_c (
    .pclk(pclk),
    .presetn(presetn),
    .pu(pu_c.unit)
  );

  pin_unit u_unit_d (
    .pclk(pclk),
    .presetn(presetn),
    .pu(pu_d.unit)
  );

  assign channel4_pin_c_out = pu_c.pin_out;
  assign channel4_pin_c_oe = pu_c.pin_oe;
  assign channel4_pin_d_out = pu_d.pin_out;
  assign channel4_pin_d_oe = pu_d.pin_oe;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire [3:0] fc = channel4_pin_cd_io_control[FLD_C_LSB+:4];
  wire [3:0] fd = channel4_pin_cd_io_control[FLD_D_LSB+:4];
  wire hit_c = count_step && (counter_value == channel4_general_reg_c);
  wire hit_d = count_step && (counter_value == channel4_general_reg_d);
  logic sync_c_prev;
  logic sync_d_prev;
  // edge history for the checks, kept apart from the units so a unit fault shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_c_prev <= 1'b0;
      sync_d_prev <= 1'b0;
    end else begin
      sync_c_prev <= pins_sync[0];
      sync_d_prev <= pins_sync[1];
    end
  end

  wire rise_c = pins_sync[0] && !sync_c_prev;
  wire fall_c = !pins_sync[0] && sync_c_prev;
  wire rise_d = pins_sync[1] && !sync_d_prev;
  wire fall_d = !pins_sync[1] && sync_d_prev;

  sequence s_match_c_quiet;
    hit_c && !fc[SEL_INPUT_BIT] && !block_c && !io_written;
  endsequence

  sequence s_match_d_quiet;
    hit_d && !fd[SEL_INPUT_BIT] && !block_d && !io_written;
  endsequence

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable && pready;
  endsequence

  a_clear_at_match: assert property (
    s_match_c_quiet and (fc[1:0] == 2'h1) |=> !channel4_pin_c_out)
    else $error("pin c not low after clear match");

  a_set_at_match: assert property (
    s_match_c_quiet and (fc[1:0] == 2'h2) |=> channel4_pin_c_out)
    else $error("pin c not high after set match");

  a_toggle_at_match: assert property (
    s_match_c_quiet and (fc[1:0] == 2'h3)
    |=> channel4_pin_c_out != $past(channel4_pin_c_out))
    else $error("pin c did not toggle at match");

  a_init_level_d: assert property (
    io_written && !fd[SEL_INPUT_BIT] && (fd[1:0] != 2'h0) && !block_d
    |=> channel4_pin_d_out == $past(fd[SEL_INIT_BIT]))
    else $error("pin d initial level wrong");

  a_rise_capture: assert property (
    fc[SEL_INPUT_BIT] && (fc[1:0] == 2'h0) && !block_c && rise_c
    |=> channel4_general_reg_c == $past(counter_value))
    else $error("rising edge not captured on c");

  a_fall_capture: assert property (
    fc[SEL_INPUT_BIT] && (fc[1:0] == 2'h1) && !block_c && fall_c
    |=> channel4_general_reg_c == $past(counter_value))
    else $error("falling edge not captured on c");

  a_both_capture: assert property (
    fc[SEL_INPUT_BIT] && fc[1] && !block_c && (rise_c || fall_c)
    |-> pu_c.capture ##1 status[ST_CAPT_C])
    else $error("edge not captured on c in both mode");

  a_hold_keeps_pin: assert property (
    (fc == 4'h0) && !io_written |=> $stable(channel4_pin_c_out))
    else $error("pin c moved in hold mode");

  a_buffer_blocks: assert property (
    block_c |-> !pu_c.match && !pu_c.capture)
    else $error("buffer mode did not block pin c");

  a_match_flag_d: assert property (
    hit_d && !fd[SEL_INPUT_BIT] && !block_d |=> status[ST_MATCH_D] [*2])
    else $error("match on d not flagged");

  a_apb_one_wait: assert property (
    s_apb_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");

  a_unmapped_err: assert property (
    s_apb_setup and !addr_hit |=> pslverr && pready)
    else $error("unmapped address without error");

  a_irq_follows: assert property (
    |(status & mask) |=> irq)
    else $error("irq missing for unmasked status");

  a_sticky_status: assert property (
    status[ST_MATCH_C] && !(psel && penable && pready && pwrite && sel_status)
    |=> status[ST_MATCH_C])
    else $error("status bit lost without clear");

  a_clear_d_match: assert property (
    s_match_d_quiet and (fd[1:0] == 2'h1) |=> !channel4_pin_d_out)
    else $error("pin d not low after clear match");

  a_set_d_match: assert property (
    s_match_d_quiet and (fd[1:0] == 2'h2) |=> channel4_pin_d_out)
    else $error("pin d not high after set match");

  a_toggle_d_match: assert property (
    s_match_d_quiet and (fd[1:0] == 2'h3)
    |=> channel4_pin_d_out != $past(channel4_pin_d_out))
    else $error("pin d did not toggle at match");

  a_init_level_c: assert property (
    io_written && !fc[SEL_INPUT_BIT] && (fc[1:0] != 2'h0) && !block_c
    |=> channel4_pin_c_out == $past(fc[SEL_INIT_BIT]))
    else $error("pin c initial level wrong");

  a_rise_capture_d: assert property (
    fd[SEL_INPUT_BIT] && (fd[1:0] == 2'h0) && !block_d && rise_d
    |=> channel4_general_reg_d == $past(counter_value))
    else $error("rising edge not captured on d");

  a_fall_capture_d: assert property (
    fd[SEL_INPUT_BIT] && (fd[1:0] == 2'h1) && !block_d && fall_d
    |=> channel4_general_reg_d == $past(counter_value))
    else $error("falling edge not captured on d");

  a_hold_keeps_d: assert property (
    (fd == 4'h0) && !io_written |=> $stable(channel4_pin_d_out))
    else $error("pin d moved in hold mode");

  a_buffer_blocks_d: assert property (
    block_d |-> !pu_d.match && !pu_d.capture)
    else $error("buffer mode did not block pin d");

  a_buffer_no_init: assert property (
    block_c && io_written |=> $stable(channel4_pin_c_out))
    else $error("buffer mode let pin c take initial level");

  a_oe_follows_field: assert property (
    1'b1 |=> channel4_pin_c_oe == !$past(fc[SEL_INPUT_BIT]))
    else $error("pin c enable does not follow field");

  a_status_clear: assert property (
    s_apb_access and (pwrite && sel_status && pwdata[ST_MATCH_C] && !pu_c.match)
    |=> !status[ST_MATCH_C])
    else $error("status bit not cleared by write one");

endmodule : timer_ch4_io_control_cd

// ### src/timer_ch4_pkg.sv
// package: constants and types shared by the channel 4 pin c/d control block
// assumes: apb slave with 32-bit data, byte addresses, one word per register
package timer_ch4_pkg;
  localparam int CNT_W_DEF = 16;
  localparam int ADDR_W = 8;
  localparam int ST_W = 4;
  localparam logic [7:0] OFS_IO_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_GREG_C = 8'h08;
  localparam logic [7:0] OFS_GREG_D = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam int FLD_C_LSB = 0;
  localparam int FLD_D_LSB = 4;
  localparam int SEL_INPUT_BIT = 3;
  localparam int SEL_INIT_BIT = 2;
  localparam int MODE_BUF_A_BIT = 0;
  localparam int MODE_BUF_B_BIT = 1;
  localparam int ST_MATCH_C = 0;
  localparam int ST_CAPT_C = 1;
  localparam int ST_MATCH_D = 2;
  localparam int ST_CAPT_D = 3;
  localparam logic [7:0] IO_CONTROL_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic PIN_RST = 1'b0;
  localparam logic OE_RST = 1'b1;

  typedef enum logic [2:0] {
    FUNC_HOLD, FUNC_CLEAR, FUNC_SET, FUNC_TOGGLE,
    FUNC_CAPT_RISE, FUNC_CAPT_FALL, FUNC_CAPT_BOTH
  } pin_func_t;

  function automatic pin_func_t decode_func(input logic [3:0] f);
    pin_func_t r;
    r = FUNC_HOLD;
    if (f[SEL_INPUT_BIT]) begin
      if (f[1]) r = FUNC_CAPT_BOTH;
      else if (f[0]) r = FUNC_CAPT_FALL;
      else r = FUNC_CAPT_RISE;
    end else begin
      unique case (f[1:0])
        2'h0: r = FUNC_HOLD;
        2'h1: r = FUNC_CLEAR;
        2'h2: r = FUNC_SET;
        2'h3: r = FUNC_TOGGLE;
      endcase
    end
    return r;
  endfunction : decode_func
endpackage : timer_ch4_pkg

// ### verification/pin_partner.sv
// model: the two external pins of channel 4, seen from the board side
// assumes: the bench sets the levels the board would drive while the block listens
`timescale 1ns/1ps
module pin_partner (
  input wire logic drive_c,
  input wire logic drive_d,
  input wire logic c_out,
  input wire logic c_oe,
  input wire logic d_out,
  input wire logic d_oe,
  output logic c_in,
  output logic d_in
);
  // the board only drives a pin while the block has released it
  assign c_in = c_oe ? c_out : drive_c;
  assign d_in = d_oe ? d_out : drive_d;
endmodule : pin_partner

// ### verification/timer_ch4_io_control_cd_tb.sv
// bench: apb register tests plus compare and capture sequences on pins c and d
// assumes: pin_partner closes the pin loop, counter driven directly by the bench
`timescale 1ns/1ps
module timer_ch4_io_control_cd_tb;
  import timer_ch4_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, count_step, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] counter_value;
  logic c_in, c_out, c_oe, d_in, d_out, d_oe, drv_c, drv_d, rerr, pin_exp;
  logic [3:0] code;
  logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h6};
  int bad_count, num_checks;

  timer_ch4_io_control_cd #(.CNT_W(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_step(count_step),
    .counter_value(counter_value), .channel4_pin_c_in(c_in), .channel4_pin_c_out(c_out),
    .channel4_pin_c_oe(c_oe), .channel4_pin_d_in(d_in), .channel4_pin_d_out(d_out),
    .channel4_pin_d_oe(d_oe), .irq(irq));

  pin_partner board (.drive_c(drv_c), .drive_d(drv_d), .c_out(c_out), .c_oe(c_oe),
    .d_out(d_out), .d_oe(d_oe), .c_in(c_in), .d_in(d_in));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic print_verdict;
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one setup cycle, then access until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdat, exp);
    cmp({31'h0, rerr}, {31'h0, experr});
  endtask : rd

  // one counter step with the given value, then let status and irq settle
  task automatic step(input logic [15:0] v);
    @(posedge pclk);
    counter_value <= v;
    count_step <= 1'b1;
    @(posedge pclk);
    count_step <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : step

  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end

  initial begin
    bad_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, count_step, drv_c, drv_d} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    counter_value = 16'h0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cmp({29'h0, c_out, d_out, irq}, 32'h0000_0000);
    rd(OFS_IO_CONTROL, 32'h0000_0000, 1'b0);
    rd(OFS_MODE, 32'h0000_0000, 1'b0);
    rd(OFS_STATUS, 32'h0000_0000, 1'b0);
    rd(OFS_MASK, 32'h0000_0000, 1'b0);
    rd(8'h18, 32'h0000_0000, 1'b1);
    // compare modes on pin c, each checked for initial level, match action and irq
    wr(OFS_MASK, 32'h0000_0001);
    wr(OFS_GREG_C, 32'h0000_0010);
    for (int i = 0; i < 6; i++) begin
      code = codes[i];
      wr(OFS_IO_CONTROL, {28'h0, code});
      repeat (3) @(posedge pclk);
      cmp({30'h0, c_oe, c_out}, {30'h0, 1'b1, code[2]});
      step(16'h000F);
      cmp({31'h0, c_out}, {31'h0, code[2]});
      step(16'h0010);
      pin_exp = (code[1:0] == 2'h1) ? 1'b0 : (code[1:0] == 2'h2) ? 1'b1 : ~code[2];
      cmp({30'h0, c_out, irq}, {30'h0, pin_exp, 1'b1});
      rd(OFS_STATUS, 32'h0000_0001, 1'b0);
      wr(OFS_STATUS, 32'h0000_000F);
      repeat (2) @(posedge pclk);
      cmp({31'h0, irq}, 32'h0000_0000);
    end
    // hold code keeps the high level left by the last set match
    wr(OFS_IO_CONTROL, 32'h0000_0000);
    step(16'h0010);
    cmp({31'h0, c_out}, 32'h0000_0001);
    // capture on pin d: value at the rise or at the fall tells which edge fired
    for (int i = 0; i < 3; i++) begin
      code = 4'h8 + i[3:0];
      wr(OFS_IO_CONTROL, {24'h0, code, 4'h0});
      wr(OFS_STATUS, 32'h0000_000F);
      @(posedge pclk);
      counter_value <= 16'h0100 + i[15:0];
      drv_d <= 1'b1;
      repeat (6) @(posedge pclk);
      counter_value <= 16'h0200 + i[15:0];
      drv_d <= 1'b0;
      repeat (6) @(posedge pclk);
      cmp({31'h0, d_oe}, 32'h0000_0000);
      rd(OFS_GREG_D, (i == 0) ? 32'h0000_0100 : 32'h0000_0200 + i, 1'b0);
      rd(OFS_STATUS, 32'h0000_0008, 1'b0);
    end
    // buffer bit on reg c: pin c keeps its level and flags nothing, pin d still toggles
    wr(OFS_STATUS, 32'h0000_000F);
    wr(OFS_GREG_D, 32'h0000_0010);
    wr(OFS_MODE, 32'h0000_0001);
    rd(OFS_MODE, 32'h0000_0001, 1'b0);
    wr(OFS_IO_CONTROL, 32'h0000_0071);
    repeat (3) @(posedge pclk);
    cmp({30'h0, c_out, d_out}, 32'h0000_0003);
    step(16'h0010);
    cmp({30'h0, c_out, d_out}, 32'h0000_0002);
    rd(OFS_STATUS, 32'h0000_0004, 1'b0);
    // buffer bit on reg d: pin d neither loads its initial high nor flags
    wr(OFS_STATUS, 32'h0000_000F);
    wr(OFS_MODE, 32'h0000_0002);
    wr(OFS_IO_CONTROL, 32'h0000_0062);
    repeat (3) @(posedge pclk);
    cmp({30'h0, c_out, d_out}, 32'h0000_0000);
    step(16'h0010);
    cmp({30'h0, c_out, d_out}, 32'h0000_0002);
    rd(OFS_STATUS, 32'h0000_0001, 1'b0);
    print_verdict();
  end
endmodule : timer_ch4_io_control_cd_tb
